// File: verilog/acw_adc_ctrl.sv
// Converter start, timing, result and window-compare control.
`timescale 1ns/1ps
// Notes on behaviour
// - Every finished result compared against limits automatically
// - Window flag pollable and offered as interrupt
// - Two 16-bit limits, high and low bytes
// - Limit order alone picks inside or outside
// - Single-ended results compare as unsigned
// - Inside window: strictly above and strictly below
// - Outside window: strictly beyond either bound
// - Differential results are two's complement
// - Differential comparisons are signed
// - Conversion clock is system clock over divider+1
// - Justify bit picks right or left placement
// - Conversion lasts ten conversion clocks
module acw_adc_ctrl
	import acw_pkg::*;
#(
	parameter int RES_W = 10
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Special-function register bus.
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	// Start sources.
	input wire logic [3:0] timer_ovf_in,
	input wire logic external_start_pin_in,
	// Converter core.
	input wire logic diff_mode_in,
	input wire logic [RES_W-1:0] sar_result_in,
	output logic track_out,
	output logic convert_out,
	// Flags for the interrupt controller.
	output logic conversion_done_out,
	output logic window_match_out
);
	localparam int PAD = 16 - RES_W;

	acw_state_t state_q, state_d;
	logic [7:0] cn_q, cf_q, rdata_q;
	logic [15:0] gt_q, lt_q, res_q;
	logic [4:0] div_cnt_q;
	logic [3:0] phase_q;
	logic done_q, win_q, ext_q, track_q, convert_q;

	// Register writes.
	wire wr_cn = sfr_wr_in && sfr_addr_in == ADDR_CN;
	wire wr_cf = sfr_wr_in && sfr_addr_in == ADDR_CF;
	wire wr_gth = sfr_wr_in && sfr_addr_in == ADDR_GT_H;
	wire wr_gtl = sfr_wr_in && sfr_addr_in == ADDR_GT_L;
	wire wr_lth = sfr_wr_in && sfr_addr_in == ADDR_LT_H;
	wire wr_ltl = sfr_wr_in && sfr_addr_in == ADDR_LT_L;

	wire conv_en = cn_q[BIT_EN];
	wire low_power = cn_q[BIT_TM];
	wire [2:0] cm = cn_q[CM_HI:0];
	wire [4:0] div_val = cf_q[DIV_HI:DIV_LO];
	wire left_just = cf_q[BIT_LJST];
	wire idle = state_q == ST_IDLE;

	// Start trigger selection; codes 6 and 7 start nothing.
	wire busy_wr1 = wr_cn && sfr_wdata_in[BIT_BUSY];
	wire ext_rise = external_start_pin_in && !ext_q;
	wire trig = (cm == CM_WRITE) ? busy_wr1 :
		(cm == CM_TMR_A) ? timer_ovf_in[0] :
		(cm == CM_TMR_B) ? timer_ovf_in[1] :
		(cm == CM_TMR_C) ? timer_ovf_in[2] :
		(cm == CM_EXT) ? ext_rise :
		(cm == CM_TMR_D) ? timer_ovf_in[3] : 1'b0;
	wire start = idle && conv_en && trig;

	// The divider restarts with each start so the first period is full length.
	wire sar_tick = div_cnt_q == div_val;
	wire track_end = state_q == ST_TRACK && sar_tick && phase_q == TRACK_CLKS - 4'h1;
	wire finish = state_q == ST_CONV && sar_tick && phase_q == CONV_CLKS - 4'h1;

	// Result formatting and window comparison on the fresh sample.
	wire [15:0] word_r = diff_mode_in ? {{PAD{sar_result_in[RES_W-1]}}, sar_result_in} :
		{{PAD{1'b0}}, sar_result_in};
	wire [15:0] word = left_just ? {sar_result_in, {PAD{1'b0}}} : word_r;
	wire above_gt = diff_mode_in ? $signed(word) > $signed(gt_q) : word > gt_q;
	wire below_lt = diff_mode_in ? $signed(word) < $signed(lt_q) : word < lt_q;
	wire inside_mode = diff_mode_in ? $signed(lt_q) > $signed(gt_q) : lt_q > gt_q;
	wire win_hit = inside_mode ? (above_gt && below_lt) : (above_gt || below_lt);

	// Normal mode tracks whenever enabled and not converting.
	wire track_d = state_d == ST_TRACK || (!low_power && conv_en && state_d == ST_IDLE);

	wire [7:0] cn_rd = {cn_q[7:6], done_q, !idle, win_q, cm};
	wire [7:0] rd_mux = (sfr_addr_in == ADDR_CN) ? cn_rd :
		(sfr_addr_in == ADDR_CF) ? {cf_q[7:2], 2'h0} :
		(sfr_addr_in == ADDR_RES_H) ? res_q[15:8] :
		(sfr_addr_in == ADDR_RES_L) ? res_q[7:0] :
		(sfr_addr_in == ADDR_GT_H) ? gt_q[15:8] :
		(sfr_addr_in == ADDR_GT_L) ? gt_q[7:0] :
		(sfr_addr_in == ADDR_LT_H) ? lt_q[15:8] :
		(sfr_addr_in == ADDR_LT_L) ? lt_q[7:0] : 8'h00;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d = low_power ? ST_TRACK : ST_CONV;
				end
			end
			ST_TRACK: begin
				if (track_end) begin
					state_d = ST_CONV;
				end
			end
			ST_CONV: begin
				if (finish) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		if (!conv_en) begin
			state_d = ST_IDLE;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q <= ST_IDLE;
			div_cnt_q <= 5'h00;
			phase_q <= 4'h0;
		end else begin
			state_q <= state_d;
			div_cnt_q <= (start || sar_tick) ? 5'h00 : div_cnt_q + 5'h01;
			if (start || track_end || finish) begin
				phase_q <= 4'h0;
			end else if (sar_tick && !idle) begin
				phase_q <= phase_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cn_q <= RST_CN;
			cf_q <= RST_CF;
			gt_q <= RST_GT;
			lt_q <= RST_LT;
		end else begin
			if (wr_cn) begin
				cn_q <= sfr_wdata_in;
			end
			if (wr_cf) begin
				cf_q <= sfr_wdata_in;
			end
			if (wr_gth) begin
				gt_q[15:8] <= sfr_wdata_in;
			end
			if (wr_gtl) begin
				gt_q[7:0] <= sfr_wdata_in;
			end
			if (wr_lth) begin
				lt_q[15:8] <= sfr_wdata_in;
			end
			if (wr_ltl) begin
				lt_q[7:0] <= sfr_wdata_in;
			end
		end
	end

	// A flag event in the same cycle as a software clear keeps the flag set.
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			done_q <= 1'b0;
			win_q <= 1'b0;
			res_q <= 16'h0000;
		end else begin
			done_q <= finish || (wr_cn ? sfr_wdata_in[BIT_DONE] : done_q);
			win_q <= (finish && win_hit) ||
				(wr_cn ? sfr_wdata_in[BIT_WIN] : win_q);
			if (finish) begin
				res_q <= word;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ext_q <= 1'b0;
			track_q <= 1'b0;
			convert_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ext_q <= external_start_pin_in;
			track_q <= track_d;
			convert_q <= state_d == ST_CONV;
			rdata_q <= rd_mux;
		end
	end

	assign sfr_rdata_out = rdata_q;
	assign track_out = track_q;
	assign convert_out = convert_q;
	assign conversion_done_out = done_q;
	assign window_match_out = win_q;

	// Separate count of conversion clocks, kept apart from phase_q so the length check is not
	// derived from the counter it guards.
	logic [3:0] conv_ticks_q;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || state_q != ST_CONV) begin
			conv_ticks_q <= 4'h0;
		end else if (sar_tick) begin
			conv_ticks_q <= conv_ticks_q + 4'h1;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	chk_done_on_finish: assert property (finish |=> done_q && idle)
		else $error("done flag not set when busy fell");
	chk_conv_length: assert property (state_q == ST_CONV && sar_tick
		|-> finish == (conv_ticks_q == CONV_CLKS - 4'h1))
		else $error("conversion length wrong");
	chk_track_length: assert property (state_q == ST_TRACK && state_d == ST_CONV
		|-> sar_tick && phase_q == TRACK_CLKS - 4'h1)
		else $error("tracking phase length wrong");
	chk_inside_hit: assert property (finish && inside_mode && above_gt && below_lt
		|=> win_q)
		else $error("inside result did not raise window flag");
	chk_no_hit_clear: assert property (finish && !win_hit && !win_q && !wr_cn
		|=> !win_q)
		else $error("window flag set without a hit");
	chk_signed_below: assert property (finish && diff_mode_in && !inside_mode &&
		$signed(word) < $signed(lt_q) |=> win_q)
		else $error("signed outside result missed");
	chk_reserved_idle: assert property (idle && cm[2:1] == 2'b11 |=> idle)
		else $error("reserved start code started a conversion");
	chk_flag_sticky: assert property (done_q && win_q && !wr_cn |=> done_q && win_q)
		else $error("flag dropped without software clear");
	chk_poll_read: assert property (sfr_addr_in == ADDR_CN
		|=> sfr_rdata_out[BIT_WIN] == $past(win_q))
		else $error("window flag not readable in control register");
	chk_left_zero: assert property (finish && left_just |=> res_q[PAD-1:0] == 0)
		else $error("left justified result has low bits set");
	chk_limit_load: assert property (wr_gth |=> gt_q[15:8] == $past(sfr_wdata_in))
		else $error("limit high byte not loaded");
	chk_div_tick: assert property (!idle && sar_tick |=> !sar_tick || div_val == 5'h00)
		else $error("conversion clock faster than divider allows");

	cov_inside: cover property (finish && inside_mode && win_hit);
	cov_outside: cover property (finish && !inside_mode && win_hit);
	cov_low_power: cover property (state_q == ST_TRACK ##1 state_q == ST_CONV);
	cov_ext_start: cover property (start && cm == CM_EXT);
endmodule

// File: include/acw_pkg.sv
// Constants for the converter control and window detector block.
package acw_pkg;
	// Register addresses on the special-function register bus.
	localparam logic [7:0] ADDR_CN = 8'he8;
	localparam logic [7:0] ADDR_CF = 8'hbc;
	localparam logic [7:0] ADDR_RES_H = 8'hbe;
	localparam logic [7:0] ADDR_RES_L = 8'hbd;
	localparam logic [7:0] ADDR_GT_H = 8'hc4;
	localparam logic [7:0] ADDR_GT_L = 8'hc3;
	localparam logic [7:0] ADDR_LT_H = 8'hc6;
	localparam logic [7:0] ADDR_LT_L = 8'hc5;
	// Reset values.
	localparam logic [7:0] RST_CN = 8'h00;
	localparam logic [7:0] RST_CF = 8'hf8;
	localparam logic [15:0] RST_GT = 16'hffff;
	localparam logic [15:0] RST_LT = 16'h0000;
	// Control and status bit positions.
	localparam int BIT_EN = 7;
	localparam int BIT_TM = 6;
	localparam int BIT_DONE = 5;
	localparam int BIT_BUSY = 4;
	localparam int BIT_WIN = 3;
	localparam int CM_HI = 2;
	// Configuration field positions.
	localparam int DIV_HI = 7;
	localparam int DIV_LO = 3;
	localparam int BIT_LJST = 2;
	// Start source codes.
	localparam logic [2:0] CM_WRITE = 3'h0;
	localparam logic [2:0] CM_TMR_A = 3'h1;
	localparam logic [2:0] CM_TMR_B = 3'h2;
	localparam logic [2:0] CM_TMR_C = 3'h3;
	localparam logic [2:0] CM_EXT = 3'h4;
	localparam logic [2:0] CM_TMR_D = 3'h5;
	// Phase lengths in conversion clocks.
	localparam logic [3:0] TRACK_CLKS = 4'h3;
	localparam logic [3:0] CONV_CLKS = 4'ha;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TRACK = 3'b010,
		ST_CONV = 3'b100
	} acw_state_t;
endpackage

// File: testbench/tb_top.sv
// Self-checking bench for the converter control and window detector.
`timescale 1ns/1ps
module tb_top;
	import acw_pkg::*;
	typedef struct packed {
		logic diff;
		logic ljst;
		logic [15:0] gt;
		logic [15:0] lt;
		logic [9:0] res;
		logic win;
	} acw_row_t;
	localparam acw_row_t ROWS [11] = '{
		'{1'b0, 1'b0, 16'h0040, 16'h0080, 10'h041, 1'b1},
		'{1'b0, 1'b0, 16'h0040, 16'h0080, 10'h040, 1'b0},
		'{1'b0, 1'b0, 16'h0040, 16'h0080, 10'h080, 1'b0},
		'{1'b0, 1'b0, 16'h0080, 16'h0040, 10'h03f, 1'b1},
		'{1'b0, 1'b0, 16'h0080, 16'h0040, 10'h040, 1'b0},
		'{1'b0, 1'b0, 16'h0080, 16'h0040, 10'h081, 1'b1},
		'{1'b0, 1'b0, 16'h0100, 16'h03ff, 10'h3fe, 1'b1},
		'{1'b1, 1'b0, 16'hffff, 16'h0040, 10'h000, 1'b1},
		'{1'b1, 1'b0, 16'hffff, 16'h0040, 10'h3ff, 1'b0},
		'{1'b1, 1'b0, 16'h0040, 16'hffff, 10'h3fe, 1'b1},
		'{1'b0, 1'b1, 16'h1000, 16'h2000, 10'h041, 1'b1}
	};
	localparam logic [7:0] RA [8] = '{ADDR_CN, ADDR_CF, ADDR_GT_H, ADDR_GT_L, ADDR_LT_H,
		ADDR_LT_L, ADDR_RES_L, 8'hff};
	localparam logic [7:0] RV [8] = '{RST_CN, RST_CF, RST_GT[15:8], RST_GT[7:0], RST_LT[15:8],
		RST_LT[7:0], 8'h00, 8'h00};
	localparam logic [2:0] CODES [5] = '{CM_TMR_A, CM_TMR_B, CM_TMR_C, CM_TMR_D, CM_EXT};
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [3:0] tmr = 4'h0;
	logic pin = 1'b0;
	logic diff = 1'b0;
	logic [9:0] sar = 10'h000;
	logic [7:0] rdata;
	logic trk, cnv, done, win;
	logic [15:0] word;
	int n_mismatch = 0;
	int n_tests = 0;
	int n_trk;
	int n_cnv;
	always #20 clk_in = ~clk_in;
	acw_adc_ctrl DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
		.sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .timer_ovf_in(tmr),
		.external_start_pin_in(pin), .diff_mode_in(diff), .sar_result_in(sar),
		.track_out(trk), .convert_out(cnv), .conversion_done_out(done), .window_match_out(win));
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk8(logic [7:0] got, logic [7:0] exp, string what);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic chk1(logic got, logic exp, string what);
		chk8({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic chkn(int got, int exp, string what);
		chk8(got[7:0], exp[7:0], what);
	endtask
	task automatic wrr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge clk_in);
		addr <= a;
		@(posedge clk_in);
		#1;
		chk8(rdata, exp, "read");
	endtask
	// Counts tracking and converting cycles until the done flag shows up.
	// The first sample is taken just after the start edge, so that cycle is counted too.
	task automatic wait_done();
		n_trk = 0;
		n_cnv = 0;
		#1;
		for (int i = 0; i < 400 && done !== 1'b1; i++) begin
			n_trk += (trk === 1'b1);
			n_cnv += (cnv === 1'b1);
			@(posedge clk_in);
			#1;
		end
		if (done !== 1'b1) begin
			chk1(done, 1'b1, "timeout");
			end_of_test();
		end
	endtask
	initial begin
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int r = 0; r < 11; r++) begin
			@(posedge clk_in);
			diff <= ROWS[r].diff;
			sar <= ROWS[r].res;
			wrr(ADDR_CF, {5'h00, ROWS[r].ljst, 2'h0});
			wrr(ADDR_GT_H, ROWS[r].gt[15:8]);
			wrr(ADDR_GT_L, ROWS[r].gt[7:0]);
			wrr(ADDR_LT_H, ROWS[r].lt[15:8]);
			wrr(ADDR_LT_L, ROWS[r].lt[7:0]);
			wrr(ADDR_CN, 8'h80);
			wrr(ADDR_CN, 8'h90);
			wait_done();
			chkn(n_cnv, 10, "conversion length");
			chkn(n_trk, 0, "tracking while busy");
			chk1(cnv, 1'b0, "busy at done");
			chk1(trk, 1'b1, "normal tracking when idle");
			chk1(win, ROWS[r].win, "window");
			rd(ADDR_CN, {4'ha, ROWS[r].win, 3'h0});
			word = ROWS[r].ljst ? {ROWS[r].res, 6'h00} : {{6{ROWS[r].diff & ROWS[r].res[9]}},
				ROWS[r].res};
			rd(ADDR_RES_H, word[15:8]);
			rd(ADDR_RES_L, word[7:0]);
			$display("row %0d done", r);
		end
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		#1;
		chk1(done, 1'b0, "done after reset");
		for (int k = 0; k < 8; k++) begin
			rd(RA[k], RV[k]);
		end
		wrr(ADDR_CF, 8'hff);
		rd(ADDR_CF, 8'hfc);
		$display("reset test done");
		// Low power, divider 4: three and ten phases stretched by five.
		wrr(ADDR_CF, 8'h20);
		wrr(ADDR_CN, 8'hc0);
		wrr(ADDR_CN, 8'hd0);
		wait_done();
		chkn(n_trk, 15, "track length");
		chkn(n_cnv, 50, "divided length");
		$display("low power test done");
		for (int k = 0; k < 5; k++) begin
			wrr(ADDR_CN, {5'h10, CODES[k]});
			@(posedge clk_in);
			tmr <= (k < 4) ? 4'h1 << k : 4'h0;
			pin <= (k == 4);
			@(posedge clk_in);
			tmr <= 4'h0;
			pin <= 1'b0;
			wait_done();
			chkn(n_cnv, 50, "trigger");
		end
		wrr(ADDR_CN, 8'h86);
		@(posedge clk_in);
		tmr <= 4'hf;
		pin <= 1'b1;
		@(posedge clk_in);
		tmr <= 4'h0;
		pin <= 1'b0;
		repeat (60) @(posedge clk_in);
		#1;
		chk1(done, 1'b0, "reserved code");
		$display("trigger test done");
		wrr(ADDR_CN, 8'h80);
		wrr(ADDR_CN, 8'h90);
		repeat (5) @(posedge clk_in);
		#1;
		chk1(cnv, 1'b1, "abort running");
		wrr(ADDR_CN, 8'h00);
		repeat (60) @(posedge clk_in);
		#1;
		chk1(done, 1'b0, "abort flag");
		chk1(cnv, 1'b0, "abort busy");
		$display("abort test done");
		end_of_test();
	end
endmodule
